// file: hw/rit_pkg.sv
package rit_pkg;

  // Channel counts and widths.
  localparam int NCH     = 11;
  localparam int NG1     = 5;
  localparam int NG2     = 6;
  localparam int CW      = 16;
  localparam int G2_SRC  = 7;
  localparam int PRESC_W = 8;

  // Per-channel control field positions.
  localparam int CTL_W    = 7;
  localparam int CTL_MODE = 0;
  localparam int CTL_DOWN = 3;
  localparam int CTL_TSEL = 4;
  localparam int CTL_TEN  = 6;
  localparam int CTL_RLD  = 16;

  // Count limits and reset values.
  localparam logic [15:0] PWM_MAX   = 16'hFFFE;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [10:0] MASK_RST  = 11'h000;
  localparam logic [7:0]  PRESC_RST = 8'h00;

  // Register byte offsets.
  localparam logic [7:0] OFS_START  = 8'h00;
  localparam logic [7:0] OFS_OSTRIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_PRESC  = 8'h10;
  localparam logic [7:0] OFS_CH     = 8'h40;
  localparam logic [7:0] OFS_CH_END = 8'h98;

  // Operating modes of one channel.
  typedef enum logic [2:0] {
    M_INTERVAL = 3'b000,
    M_PWM      = 3'b001,
    M_EVENT    = 3'b010,
    M_ONESHOT  = 3'b011,
    M_PERIOD   = 3'b100,
    M_WIDTH    = 3'b101
  } rit_mode_e;

  // Start trigger sources of a first-group channel.
  typedef enum logic [1:0] {
    TSEL_PIN  = 2'b00,
    TSEL_G2   = 2'b01,
    TSEL_PREV = 2'b10,
    TSEL_NEXT = 2'b11
  } rit_tsel_e;

endpackage

// file: hw/rit_chan_if.sv
interface rit_chan_if;
  logic        tick;
  logic        run;
  logic        wr;
  logic        trig;
  logic        pin;
  logic [15:0] wdata;
  logic [6:0]  ctrl;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic        out;
  logic        ev_uf;
  logic        ev_ov;
  logic        ev_edge;
  logic        ev_pwm;

  // Register file side.
  modport ctl (output tick, run, wr, trig, pin, wdata, ctrl,
               input cnt, rld, out, ev_uf, ev_ov, ev_edge, ev_pwm);
  // Channel side.
  modport chan (input tick, run, wr, trig, pin, wdata, ctrl,
                output cnt, rld, out, ev_uf, ev_ov, ev_edge, ev_pwm);
endinterface

// file: hw/rit_chan.sv
module rit_chan (
  // Clock and reset.
  input wire logic  clock,
  input wire logic  rst_n,
  // Register file link.
  rit_chan_if.chan  cif
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        out;
    logic        pin_q;
    logic        run_q;
    logic        armed;
    logic        seen;
    logic        uf;
    logic        ov;
    logic        edge_ev;
    logic        pwm;
  } rit_chs_s;

  rit_chs_s           s_r;
  rit_chs_s           s_nxt;
  rit_pkg::rit_mode_e mode;
  logic               rise;
  logic               fall;
  logic               start;
  logic               meas;
  logic               pwm_hi;
  logic [15:0]        wval;
  logic [15:0]        pwm_up;

  // Decode of the mode field and the pin and run edges.
  assign mode   = rit_pkg::rit_mode_e'(cif.ctrl[2:0]);
  assign rise   = cif.pin & ~s_r.pin_q;
  assign fall   = ~cif.pin & s_r.pin_q;
  assign start  = cif.run & ~s_r.run_q;
  assign meas   = (mode == rit_pkg::M_PERIOD) ? rise : (rise | fall);
  assign pwm_up = (s_r.cnt >= rit_pkg::PWM_MAX) ? 16'h0000
                                                : s_r.cnt + 16'h0001;
  assign pwm_hi = pwm_up < s_r.rld;
  // PWM clamps each value written while in that mode inside its shorter range.
  assign wval   = (mode == rit_pkg::M_PWM && cif.wdata > rit_pkg::PWM_MAX)
                  ? rit_pkg::PWM_MAX : cif.wdata;

  // Next state of the counter, reload register and output.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.uf      = 1'b0;
    s_nxt.ov      = 1'b0;
    s_nxt.edge_ev = 1'b0;
    s_nxt.pwm     = 1'b0;
    s_nxt.pin_q   = cif.pin;
    s_nxt.run_q   = cif.run;
    if (start) begin
      s_nxt.seen = 1'b0;
    end
    if (cif.wr) begin
      s_nxt.rld = wval;
      if (!cif.run) begin
        s_nxt.cnt = wval;
      end
    end
    if (!cif.run) begin
      s_nxt.armed = 1'b0;
      s_nxt.out   = 1'b0;
    end else begin
      unique case (mode)
        rit_pkg::M_INTERVAL: begin
          if (cif.tick) begin
            if (s_r.cnt == 16'h0000) begin
              s_nxt.cnt = s_r.rld;
              s_nxt.uf  = 1'b1;
              s_nxt.out = ~s_r.out;
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end
        rit_pkg::M_EVENT: begin
          if (rise && cif.ctrl[rit_pkg::CTL_DOWN]) begin
            if (s_r.cnt == 16'h0000) begin
              s_nxt.cnt = s_r.rld;
              s_nxt.uf  = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end else if (rise) begin
            if (s_r.cnt == rit_pkg::CNT_MAX) begin
              s_nxt.cnt = s_r.rld;
              s_nxt.ov  = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end
        end
        rit_pkg::M_ONESHOT: begin
          if (cif.trig && !s_r.armed) begin
            s_nxt.armed = 1'b1;
            s_nxt.cnt   = s_r.rld;
            s_nxt.out   = 1'b1;
          end else if (s_r.armed && cif.tick) begin
            if (s_r.cnt == 16'h0000) begin
              s_nxt.armed = 1'b0;
              s_nxt.out   = 1'b0;
              s_nxt.uf    = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end
        rit_pkg::M_PWM: begin
          if (cif.tick) begin
            s_nxt.cnt = pwm_up;
            s_nxt.out = pwm_hi;
            s_nxt.pwm = s_r.out & ~pwm_hi;
          end
        end
        rit_pkg::M_PERIOD, rit_pkg::M_WIDTH: begin
          if (meas) begin
            s_nxt.rld     = s_r.cnt;
            s_nxt.cnt     = 16'h0000;
            s_nxt.edge_ev = s_r.seen & ~start;
            s_nxt.seen    = 1'b1;
          end else if (cif.tick) begin
            if (s_r.cnt == rit_pkg::CNT_MAX) begin
              s_nxt.ov  = 1'b1;
              s_nxt.cnt = 16'h0000;
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end
        end
        default: begin
          s_nxt.out = 1'b0;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs towards the register file, all from flip-flops.
  assign cif.cnt     = s_r.cnt;
  assign cif.rld     = s_r.rld;
  assign cif.out     = s_r.out;
  assign cif.ev_uf   = s_r.uf;
  assign cif.ev_ov   = s_r.ov;
  assign cif.ev_edge = s_r.edge_ev;
  assign cif.ev_pwm  = s_r.pwm;

  // Checks of the counting behaviour.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_STOP_HOLDS: assert property (
    !cif.run && !cif.wr |=> s_r.cnt == $past(s_r.cnt))
    else $error("Stopped counter moved.");
  AST_STOPPED_WRITE: assert property (
    cif.wr && !cif.run |=> s_r.cnt == $past(wval) && s_r.rld == $past(wval))
    else $error("Stopped write missed counter or reload.");
  AST_RUN_WRITE: assert property (
    cif.wr && cif.run && mode == rit_pkg::M_INTERVAL && !cif.tick
    |=> s_r.cnt == $past(s_r.cnt) && s_r.rld == $past(wval))
    else $error("Running write touched the counter.");
  AST_RELOAD: assert property (
    cif.run && mode == rit_pkg::M_INTERVAL && cif.tick && s_r.cnt == 16'h0000
    |=> s_r.cnt == $past(s_r.rld) && cif.ev_uf)
    else $error("Interval underflow did not reload.");
  AST_PWM_LIMIT: assert property (
    cif.run && mode == rit_pkg::M_PWM && $stable(mode)
    |=> s_r.cnt <= rit_pkg::PWM_MAX)
    else $error("PWM count passed its limit.");
  // Marks a measuring channel that has started and seen no edge yet.
  logic mmode;
  logic first_r;
  assign mmode = mode == rit_pkg::M_PERIOD || mode == rit_pkg::M_WIDTH;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_r <= 1'b0;
    end else if (cif.run && mmode && meas) begin
      first_r <= 1'b0;
    end else if (start) begin
      first_r <= 1'b1;
    end
  end

  AST_FIRST_EDGE: assert property (
    cif.run && mmode && meas && (start || first_r) |=> !cif.ev_edge)
    else $error("First measured edge raised an event.");
  AST_LATER_EDGE: assert property (
    cif.run && mmode && meas && !start && !first_r |=> cif.ev_edge)
    else $error("Later measured edge raised no event.");
endmodule // rit_chan

// file: hw/rit_top.sv
// Implementation choices: the Avalon-MM register port and the address map.
module rit_top (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM slave, byte addressed.
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Timer pins.
  input  wire logic [4:0]  trigger_input_pin,
  input  wire logic [5:0]  measure_pin,
  output logic      [10:0] timer_out,
  // Interrupt.
  output logic             irq
);

  typedef struct packed {
    logic                           ack;
    logic [31:0]                    rdata;
    logic [10:0]                    run;
    logic [4:0]                     ostrig;
    logic [10:0]                    status;
    logic [10:0]                    mask;
    logic [7:0]                     presc;
    logic [7:0]                     pdiv;
    logic                           tick;
    logic [4:0]                     pin_q;
    logic [rit_pkg::NCH-1:0][6:0]   ctrl;
  } rit_top_s;

  rit_top_s                  s_r;
  rit_top_s                  s_nxt;
  rit_chan_if                cif [rit_pkg::NCH] ();
  wire logic [15:0]          cnt_a [rit_pkg::NCH];
  wire logic [15:0]          rld_a [rit_pkg::NCH];
  wire logic [10:0]          ev_all;
  wire logic [10:0]          uo;
  wire logic [10:0]          trig_all;
  wire logic [10:0]          pin_all;
  logic [4:0]                pin_rise;
  logic [7:0]                ch_off;
  logic [3:0]                ch_idx;
  logic                      ch_hit;
  logic                      ch_ctl;
  logic                      wr_go;
  logic                      rd_go;
  logic [10:0]               ch_wr;
  logic [10:0]               clr;
  logic [31:0]               rd;

  // Bus decode: each access takes one wait cycle.
  assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
  assign wr_go  = avs_write & s_r.ack;
  assign rd_go  = avs_read & ~s_r.ack;
  assign ch_off = avs_address - rit_pkg::OFS_CH;
  assign ch_idx = ch_off[6:3];
  assign ch_ctl = ch_off[2];
  assign ch_hit = avs_address >= rit_pkg::OFS_CH
                  && avs_address < rit_pkg::OFS_CH_END
                  && avs_address[1:0] == 2'h0;
  assign ch_wr  = (wr_go && ch_hit && !ch_ctl) ? (11'h001 << ch_idx)
                                               : 11'h000;
  assign clr    = (wr_go && avs_address == rit_pkg::OFS_STATUS)
                  ? avs_writedata[10:0] : 11'h000;

  // Both groups' pins form one vector, first group low.
  assign pin_all  = {measure_pin, trigger_input_pin};
  assign pin_rise = trigger_input_pin & ~s_r.pin_q;

  // Channel instances and their connections.
  for (genvar i = 0; i < rit_pkg::NCH; i++) begin : g_ch
    rit_chan u_chan (
      .clock (clock),
      .rst_n (rst_n),
      .cif   (cif[i])
    );
    assign cif[i].tick  = s_r.tick;
    assign cif[i].run   = s_r.run[i];
    assign cif[i].wr    = ch_wr[i];
    assign cif[i].wdata = avs_writedata[15:0];
    assign cif[i].ctrl  = s_r.ctrl[i];
    assign cif[i].pin   = pin_all[i];
    assign cif[i].trig  = trig_all[i];
    assign cnt_a[i]     = cif[i].cnt;
    assign rld_a[i]     = cif[i].rld;
    assign timer_out[i] = cif[i].out;
    assign uo[i]        = cif[i].ev_uf | cif[i].ev_ov;
    assign ev_all[i]    = uo[i] | cif[i].ev_edge | cif[i].ev_pwm;
  end

  // Start trigger selection for the first group.
  for (genvar i = 0; i < rit_pkg::NG1; i++) begin : g_trig
    localparam int PRV = (i + rit_pkg::NG1 - 1) % rit_pkg::NG1;
    localparam int NXT = (i + 1) % rit_pkg::NG1;
    rit_pkg::rit_tsel_e tsel;
    logic               hw;
    assign tsel = rit_pkg::rit_tsel_e'(s_r.ctrl[i][rit_pkg::CTL_TSEL +: 2]);
    assign hw   = (tsel == rit_pkg::TSEL_PIN)  ? pin_rise[i]
                : (tsel == rit_pkg::TSEL_G2)   ? uo[rit_pkg::G2_SRC]
                : (tsel == rit_pkg::TSEL_PREV) ? uo[PRV]
                :                                uo[NXT];
    assign trig_all[i] = s_r.ostrig[i]
                         | (s_r.ctrl[i][rit_pkg::CTL_TEN] & hw);
  end
  assign trig_all[10:5] = 6'h00;

  // Read multiplexer.
  always_comb begin
    rd = 32'h0000_0000;
    if (ch_hit && ch_ctl) begin
      rd = {rld_a[ch_idx], 9'h000, s_r.ctrl[ch_idx]};
    end else if (ch_hit) begin
      rd = {16'h0000, cnt_a[ch_idx]};
    end else begin
      case (avs_address)
        rit_pkg::OFS_START:  rd = {21'h000000, s_r.run};
        rit_pkg::OFS_STATUS: rd = {21'h000000, s_r.status};
        rit_pkg::OFS_MASK:   rd = {21'h000000, s_r.mask};
        rit_pkg::OFS_PRESC:  rd = {24'h000000, s_r.presc};
        default:             rd = 32'h0000_0000;
      endcase
    end
  end

  // Next state of the bus slave, registers and count source.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.ack    = (avs_read | avs_write) & ~s_r.ack;
    s_nxt.ostrig = 5'h00;
    s_nxt.pin_q  = trigger_input_pin;
    if (rd_go) begin
      s_nxt.rdata = rd;
    end
    if (s_r.pdiv >= s_r.presc) begin
      s_nxt.pdiv = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pdiv = s_r.pdiv + 8'h01;
      s_nxt.tick = 1'b0;
    end
    // A new event wins over a clear in the same cycle.
    s_nxt.status = (s_r.status & ~clr) | ev_all;
    if (wr_go) begin
      if (ch_hit && ch_ctl) begin
        s_nxt.ctrl[ch_idx] = avs_writedata[6:0];
      end
      case (avs_address)
        rit_pkg::OFS_START:  s_nxt.run    = avs_writedata[10:0];
        rit_pkg::OFS_OSTRIG: s_nxt.ostrig = avs_writedata[4:0];
        rit_pkg::OFS_MASK:   s_nxt.mask   = avs_writedata[10:0];
        rit_pkg::OFS_PRESC:  s_nxt.presc  = avs_writedata[7:0];
        default:             s_nxt.presc  = s_r.presc;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs from registers.
  assign avs_readdata = s_r.rdata;
  assign irq          = |(s_r.status & s_r.mask);

  // Checks of the bus, interrupts and start controls.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_BUS_ANSWER: assert property (
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer not after one wait cycle.");
  AST_SET_WINS: assert property (
    ev_all != 11'h000 |=> (s_r.status & $past(ev_all)) == $past(ev_all))
    else $error("Event lost from status.");
  AST_RUN_BITS: assert property (
    wr_go && avs_address == rit_pkg::OFS_START
    |=> s_r.run == $past(avs_writedata[10:0]))
    else $error("Run bits not taken from write.");
  AST_SOFT_TRIG: assert property (
    wr_go && avs_address == rit_pkg::OFS_OSTRIG && avs_writedata[0]
    |=> trig_all[0] ##1 !s_r.ostrig[0])
    else $error("Soft trigger not a single pulse.");
  AST_COUNT_READ: assert property (
    rd_go && ch_hit && !ch_ctl && ch_idx == 4'h0
    |=> avs_readdata == {16'h0000, $past(cnt_a[0])})
    else $error("Count read returned wrong value.");
  AST_IRQ_CAUSE: assert property (
    $rose(irq) |-> ($past(ev_all) & s_r.mask) != 11'h000
                   || $past(s_r.mask) != s_r.mask)
    else $error("Interrupt rose without a cause.");

  // Bus handshake: one wait cycle on writes, none while idle, one apply.
  AST_WRITE_ANSWER: assert property (
    avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("Write answer not after one wait cycle.");

  AST_IDLE_READY: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("Wait request raised with no access.");

  AST_ONE_APPLY: assert property (
    avs_write && !avs_waitrequest |=> !wr_go)
    else $error("One write applied twice.");

  AST_CH_WRITE_ONE: assert property (
    $onehot0(ch_wr))
    else $error("Count write reached more than one channel.");

  // Register contents after writes and reads.
  AST_MASK_BITS: assert property (
    wr_go && avs_address == rit_pkg::OFS_MASK
    |=> s_r.mask == $past(avs_writedata[10:0]))
    else $error("Mask bits not taken from write.");

  AST_PRESC_BITS: assert property (
    wr_go && avs_address == rit_pkg::OFS_PRESC
    |=> s_r.presc == $past(avs_writedata[7:0]))
    else $error("Prescale not taken from write.");

  AST_STATUS_CLEAR: assert property (
    clr != 11'h000 && ev_all == 11'h000
    |=> (s_r.status & $past(clr)) == 11'h000)
    else $error("Status bit not cleared by a one.");

  AST_STATUS_KEEP: assert property (
    wr_go && avs_address == rit_pkg::OFS_STATUS
    |=> ($past(s_r.status) & ~$past(avs_writedata[10:0]) & ~s_r.status)
        == 11'h000)
    else $error("Status bit cleared by a zero.");

  AST_STATUS_READ: assert property (
    rd_go && avs_address == rit_pkg::OFS_STATUS
    |=> avs_readdata == {21'h00000, $past(s_r.status)})
    else $error("Status read returned wrong value.");

  AST_UNMAPPED_READ: assert property (
    rd_go && !ch_hit && avs_address > rit_pkg::OFS_PRESC
    |=> avs_readdata == 32'h0000_0000)
    else $error("Unmapped read returned nonzero.");

  // Count source and stopped channels.
  AST_TICK_EVERY: assert property (
    s_r.presc == 8'h00 |=> s_r.tick)
    else $error("Tick missing with no prescale.");

  AST_TICK_GAP: assert property (
    s_r.tick && s_r.presc != 8'h00 |=> !s_r.tick)
    else $error("Ticks too close with prescale.");

  AST_STOP_OUT: assert property (
    s_r.run != 11'h7FF |=> (timer_out & ~$past(s_r.run)) == 11'h000)
    else $error("Stopped channel drove its output.");

  // Start triggers of the first group.
  AST_PIN_TRIG: assert property (
    s_r.ctrl[3][rit_pkg::CTL_TEN]
    && s_r.ctrl[3][rit_pkg::CTL_TSEL +: 2] == rit_pkg::TSEL_PIN
    && trigger_input_pin[3] && !s_r.pin_q[3] |-> trig_all[3])
    else $error("Pin edge did not trigger its channel.");

  AST_WRAP_NEXT: assert property (
    s_r.ctrl[4][rit_pkg::CTL_TEN]
    && s_r.ctrl[4][rit_pkg::CTL_TSEL +: 2] == rit_pkg::TSEL_NEXT
    && (cif[0].ev_uf || cif[0].ev_ov) |-> trig_all[4])
    else $error("Channel 0 did not trigger channel 4.");
endmodule // rit_top

// file: test/rit_pin_model.sv
module rit_pin_model #(
  parameter int HI_LEN = 4
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Pulse request from the bench.
  input  wire logic       fire,
  input  wire logic [3:0] idx,
  // Pins towards the timer bank.
  output logic      [4:0] trig_pin,
  output logic      [5:0] meas_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] pins_r;
  int          left_r;

  // Each request raises one pin for a fixed span, then drops it low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_r <= 11'h000;
      left_r <= 0;
    end else if (fire) begin
      pins_r <= 11'h001 << idx;
      left_r <= HI_LEN;
    end else if (left_r != 0) begin
      left_r <= left_r - 1;
    end else begin
      pins_r <= 11'h000;
    end
  end

  // Channels 0 to 4 see trigger pins, 5 to 10 see measure pins.
  assign trig_pin = pins_r[4:0];
  assign meas_pin = pins_r[10:5];
endmodule // rit_pin_model

// file: test/rit_top_tb.sv
module rit_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  trig_pin;
  logic [5:0]  meas_pin;
  logic [10:0] timer_out;
  logic        irq;
  logic        fire = 1'b0;
  logic [3:0]  pin_idx = 4'h0;
  logic [31:0] rd;
  logic [15:0] held;
  int          errors = 0;
  int          total_checks = 0;

  // Free-running 250 MHz clock.
  always #2 clock = ~clock;

  rit_top DUT (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_input_pin(trig_pin),
    .measure_pin(meas_pin), .timer_out(timer_out), .irq(irq));

  rit_pin_model u_pins (
    .clock(clock), .rst_n(rst_n), .fire(fire), .idx(pin_idx),
    .trig_pin(trig_pin), .meas_pin(meas_pin));

  // Byte address of the count and control words of channel i.
  function automatic logic [7:0] ca(input int i);
    return rit_pkg::OFS_CH + 8'(8 * i);
  endfunction
  function automatic logic [7:0] ct(input int i);
    return ca(i) + 8'h04;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clock);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) chk("bus answer", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Polls the status word until bit i is set or the tries run out.
  task automatic stat_wait(input int i, input int tries);
    rd = 32'h0;
    while (rd[i] !== 1'b1 && tries > 0) begin
      bus(1'b0, rit_pkg::OFS_STATUS, 32'h0);
      tries--;
    end
  endtask

  task automatic wait_out(input int i, input int n);
    while (timer_out[i] !== 1'b1 && n > 0) begin
      @(negedge clock);
      n--;
    end
  endtask

  // Asks the pin model for one high pulse, then leaves a gap.
  task automatic pulse(input logic [3:0] i);
    @(posedge clock);
    fire    <= 1'b1;
    pin_idx <= i;
    @(posedge clock);
    fire <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  task automatic t_reset;
    bus(1'b0, rit_pkg::OFS_START, 32'h0);
    chk("start word", 32'h0, rd);
    bus(1'b0, rit_pkg::OFS_MASK, 32'h0);
    chk("mask word", 32'h0, rd);
    bus(1'b0, rit_pkg::OFS_PRESC, 32'h0);
    chk("prescale", 32'h0, rd);
    wr(rit_pkg::OFS_PRESC, 32'h3);
    bus(1'b0, rit_pkg::OFS_PRESC, 32'h0);
    chk("prescale set", 32'h3, rd);
    wr(rit_pkg::OFS_PRESC, 32'h0);
    chk("outputs", 32'h0, {20'h0, irq, timer_out});
    wr(ca(10), 32'h1234);
    bus(1'b0, ca(10), 32'h0);
    chk("ch10 count", 32'h1234, {16'h0, rd[15:0]});
    bus(1'b0, ct(10), 32'h0);
    chk("ch10 reload", 32'h1234, {16'h0, rd[31:16]});
    bus(1'b0, rit_pkg::OFS_CH_END, 32'h0);
    chk("past last channel", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_interval;
    wr(ca(0), 32'h28);
    wr(rit_pkg::OFS_MASK, 32'h1);
    wr(rit_pkg::OFS_START, 32'h1);
    repeat (2) @(posedge clock);
    wr(ca(0), 32'h100);
    bus(1'b0, ct(0), 32'h0);
    chk("running reload", 32'h100, {16'h0, rd[31:16]});
    bus(1'b0, ca(0), 32'h0);
    chk("count kept", 32'h1, 32'(rd[15:0] <= 16'h0028));
    stat_wait(0, 40);
    chk("underflow flag", 32'h1, 32'(rd[0]));
    chk("irq", 32'h1, 32'(irq));
    bus(1'b0, ca(0), 32'h0);
    chk("reloaded count", 32'h1, 32'(rd[15:0] > 16'h0028));
    wr(rit_pkg::OFS_START, 32'h0);
    bus(1'b0, ca(0), 32'h0);
    held = rd[15:0];
    repeat (5) @(posedge clock);
    bus(1'b0, ca(0), 32'h0);
    chk("stopped count", {16'h0, held}, {16'h0, rd[15:0]});
    wr(rit_pkg::OFS_STATUS, 32'h7FF);
    bus(1'b0, rit_pkg::OFS_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq low", 32'h0, 32'(irq));
    $display("test interval done");
  endtask

  task automatic t_pwm;
    wr(ct(1), 32'h1);
    wr(ca(1), 32'hFFFF);
    bus(1'b0, ct(1), 32'h0);
    chk("pwm limit", 32'hFFFE, {16'h0, rd[31:16]});
    // Start from zero, then raise the reload so the fall comes soon.
    wr(ca(1), 32'h0);
    wr(rit_pkg::OFS_START, 32'h2);
    repeat (2) @(posedge clock);
    wr(ca(1), 32'h40);
    wait_out(1, 20);
    chk("pwm high", 32'h1, 32'(timer_out[1]));
    stat_wait(1, 40);
    chk("pwm fall flag", 32'h1, 32'(rd[1]));
    chk("pwm low", 32'h0, 32'(timer_out[1]));
    wr(rit_pkg::OFS_START, 32'h0);
    wr(rit_pkg::OFS_STATUS, 32'h7FF);
    $display("test pwm done");
  endtask

  task automatic t_oneshot;
    wr(ct(2), 32'h3);
    wr(ca(2), 32'h5);
    wr(rit_pkg::OFS_OSTRIG, 32'h4);
    repeat (10) @(posedge clock);
    chk("idle one-shot", 32'h0, 32'(timer_out[2]));
    wr(rit_pkg::OFS_START, 32'h4);
    repeat (2) @(posedge clock);
    wr(rit_pkg::OFS_OSTRIG, 32'h4);
    wait_out(2, 10);
    chk("soft start", 32'h1, 32'(timer_out[2]));
    stat_wait(2, 20);
    chk("one-shot end", 32'h1, 32'(rd[2]));
    chk("one-shot low", 32'h0, 32'(timer_out[2]));
    wr(ct(3), 32'h43);
    wr(ca(3), 32'h14);
    wr(ct(4), 32'h73);
    wr(ca(4), 32'h14);
    wr(ca(0), 32'h6);
    wr(rit_pkg::OFS_START, 32'h18);
    pulse(4'h3);
    chk("pin start", 32'h1, 32'(timer_out[3]));
    chk("no neighbour yet", 32'h0, 32'(timer_out[4]));
    wr(rit_pkg::OFS_START, 32'h19);
    wait_out(4, 40);
    chk("wrap neighbour", 32'h1, 32'(timer_out[4]));
    wr(rit_pkg::OFS_START, 32'h0);
    $display("test one-shot done");
  endtask

  task automatic t_measure;
    wr(ct(5), 32'h4);
    wr(ct(8), 32'h5);
    wr(ct(6), 32'h2);
    wr(ca(6), 32'h0);
    wr(rit_pkg::OFS_STATUS, 32'h7FF);
    wr(rit_pkg::OFS_START, 32'h160);
    pulse(4'h5);
    pulse(4'h8);
    bus(1'b0, rit_pkg::OFS_STATUS, 32'h0);
    chk("first edge quiet", 32'h0, 32'(rd[5]));
    chk("width fall flag", 32'h1, 32'(rd[8]));
    pulse(4'h5);
    bus(1'b0, rit_pkg::OFS_STATUS, 32'h0);
    chk("period flag", 32'h1, 32'(rd[5]));
    repeat (3) pulse(4'h6);
    bus(1'b0, ca(6), 32'h0);
    chk("event count", 32'h3, {16'h0, rd[15:0]});
    wr(rit_pkg::OFS_START, 32'h0);
    $display("test measure done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_interval;
    t_pwm;
    t_oneshot;
    t_measure;
    stop_test;
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (30000) @(posedge clock);
    chk("watchdog", 32'h0, 32'h1);
    stop_test;
  end
endmodule // rit_top_tb
